// ==== core/ssr_defines.svh ====
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define SSR_IDX_GO 6'h0C
`define SSR_IDX_ENTRY_FIRST 6'h0F
`define SSR_IDX_ENTRY_LAST 6'h16
`define SSR_IDX_REPEAT_LOW 6'h17
`define SSR_IDX_REPEAT_HIGH 6'h18
`define SSR_IDX_STATUS 6'h1F

`define SSR_RESET_BYTE 8'h00
`define SSR_SLOT_LAST 3'h7
`define SSR_REPEAT_ZERO 2'h0
`define SSR_WAIT_FLAG_BIT 7
`define SSR_VALUE_ZERO 7'h00
`define SSR_GO_BIT 0

// Wait unit and clock period, both in nanoseconds.
`define SSR_WAIT_UNIT_NS 10000000
`define SSR_CLK_PERIOD_NS 4

`endif

// ==== core/ssr_pkg.sv ====
`default_nettype none
package ssr_pkg;

  typedef enum logic [4:0] {
    SSR_ST_IDLE = 5'b00001,
    SSR_ST_FETCH = 5'b00010,
    SSR_ST_PLAY = 5'b00100,
    SSR_ST_WAIT = 5'b01000,
    SSR_ST_NEXT = 5'b10000
  } ssr_state_t;

endpackage : ssr_pkg
`default_nettype wire

// ==== core/ssr_slot_step.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.svh"

module ssr_slot_step (
  // Programmed count and plays already repeated.
  input wire logic [1:0] repeat_count,
  input wire logic [1:0] repeat_done,
  // Decision.
  output logic advance,
  output logic [1:0] next_repeat_done
);

  // The entry has played repeat_done plus one times; stop once that equals count plus one.
  assign advance = (repeat_done == repeat_count);
  assign next_repeat_done = advance ? `SSR_REPEAT_ZERO : repeat_done + 2'h1;

endmodule : ssr_slot_step
`default_nettype wire

// ==== core/ssr_top.sv ====
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.svh"

module ssr_top #(
  parameter int WAIT_UNIT_CYCLES = `SSR_WAIT_UNIT_NS / `SSR_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Waveform playback engine.
  output logic play_req,
  output logic [6:0] play_id,
  input wire logic play_done,
  // Sequencer state.
  output logic seq_busy
);

  logic [7:0] slot_entry [8];
  logic [7:0] slot_repeat_counts_low;
  logic [7:0] slot_repeat_counts_high;
  ssr_pkg::ssr_state_t state;
  ssr_pkg::ssr_state_t next_state;
  logic [2:0] slot;
  logic [2:0] next_slot;
  logic [1:0] repeat_done;
  logic [1:0] next_repeat_done_fsm;
  logic [6:0] wait_units;
  logic [6:0] next_wait_units;
  logic [31:0] wait_cycles;
  logic [31:0] next_wait_cycles;
  logic next_play_req;
  logic [6:0] next_play_id;
  logic step_advance;
  logic [1:0] step_next_repeat;
  logic [31:0] read_value;

  function automatic logic [1:0] slot_repeat(input logic [2:0] idx, input logic [7:0] low, input logic [7:0] high);
    logic [15:0] both;
    both = {high, low};
    slot_repeat = both[{idx, 1'b0} +: 2];
  endfunction : slot_repeat

  // Address decode.
  wire [5:0] addr_idx = paddr[7:2];
  wire addr_aligned = (paddr[1:0] == 2'h0);
  wire hit_go = addr_aligned && (addr_idx == `SSR_IDX_GO);
  wire hit_entry = addr_aligned && (addr_idx >= `SSR_IDX_ENTRY_FIRST) && (addr_idx <= `SSR_IDX_ENTRY_LAST);
  wire [5:0] entry_offset = addr_idx - `SSR_IDX_ENTRY_FIRST;
  wire [2:0] entry_sel = entry_offset[2:0];
  wire hit_low = addr_aligned && (addr_idx == `SSR_IDX_REPEAT_LOW);
  wire hit_high = addr_aligned && (addr_idx == `SSR_IDX_REPEAT_HIGH);
  wire hit_status = addr_aligned && (addr_idx == `SSR_IDX_STATUS);
  wire hit_any = hit_go || hit_entry || hit_low || hit_high || hit_status;
  wire apb_setup = psel && !penable;
  wire wr_fire = psel && penable && pready && pwrite && pstrb[0] && hit_any;
  wire go_write = wr_fire && hit_go;
  wire start = go_write && pwdata[`SSR_GO_BIT];
  wire abort = go_write && !pwdata[`SSR_GO_BIT];
  wire [7:0] cur_entry = slot_entry[slot];
  wire [6:0] cur_value = cur_entry[6:0];
  wire cur_is_wait = cur_entry[`SSR_WAIT_FLAG_BIT];
  wire [1:0] cur_repeat = slot_repeat(slot, slot_repeat_counts_low, slot_repeat_counts_high);
  wire wait_unit_end = (wait_cycles == 32'(WAIT_UNIT_CYCLES - 1));

  ssr_slot_step u_step (
    .repeat_count(cur_repeat),
    .repeat_done(repeat_done),
    .advance(step_advance),
    .next_repeat_done(step_next_repeat)
  );

  always_comb begin
    read_value = 32'h0000_0000;
    if (hit_go) begin
      read_value = {31'h0000_0000, seq_busy};
    end else if (hit_entry) begin
      read_value = {24'h00_0000, slot_entry[entry_sel]};
    end else if (hit_low) begin
      read_value = {24'h00_0000, slot_repeat_counts_low};
    end else if (hit_high) begin
      read_value = {24'h00_0000, slot_repeat_counts_high};
    end else if (hit_status) begin
      read_value = {25'h000_0000, state == ssr_pkg::SSR_ST_WAIT, repeat_done, slot, seq_busy};
    end
  end

  // Response is prepared in the setup cycle so every APB output leaves a flip-flop.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (apb_setup && !pwrite) ? read_value : 32'h0000_0000;
      pready <= apb_setup;
      pslverr <= apb_setup && !hit_any;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_repeat_counts_low <= `SSR_RESET_BYTE;
      slot_repeat_counts_high <= `SSR_RESET_BYTE;
    end else begin
      if (wr_fire && hit_low) begin
        slot_repeat_counts_low <= pwdata[7:0];
      end
      if (wr_fire && hit_high) begin
        slot_repeat_counts_high <= pwdata[7:0];
      end
    end
  end

  // Entries are rewritable during playback; a change takes effect at the next fetch.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_entry
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          slot_entry[gi] <= `SSR_RESET_BYTE;
        end else if (wr_fire && hit_entry && (entry_sel == 3'(gi))) begin
          slot_entry[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_slot = slot;
    next_repeat_done_fsm = repeat_done;
    next_wait_units = wait_units;
    next_wait_cycles = wait_cycles;
    next_play_req = 1'b0;
    next_play_id = play_id;
    if (abort) begin
      next_state = ssr_pkg::SSR_ST_IDLE;
    end else if (start) begin
      next_state = ssr_pkg::SSR_ST_FETCH;
      next_slot = 3'h0;
      next_repeat_done_fsm = `SSR_REPEAT_ZERO;
    end else begin
      case (state)
        ssr_pkg::SSR_ST_IDLE: begin
          next_state = ssr_pkg::SSR_ST_IDLE;
        end
        ssr_pkg::SSR_ST_FETCH: begin
          if (cur_value == `SSR_VALUE_ZERO) begin
            next_state = ssr_pkg::SSR_ST_IDLE;
          end else if (cur_is_wait) begin
            next_state = ssr_pkg::SSR_ST_WAIT;
            next_wait_units = cur_value;
            next_wait_cycles = 32'h0000_0000;
          end else begin
            next_state = ssr_pkg::SSR_ST_PLAY;
            next_play_req = 1'b1;
            next_play_id = cur_value;
          end
        end
        ssr_pkg::SSR_ST_PLAY: begin
          if (play_done) begin
            next_state = ssr_pkg::SSR_ST_NEXT;
          end
        end
        ssr_pkg::SSR_ST_WAIT: begin
          if (wait_unit_end) begin
            next_wait_cycles = 32'h0000_0000;
            next_wait_units = wait_units - 7'h01;
            if (wait_units == 7'h01) begin
              next_state = ssr_pkg::SSR_ST_NEXT;
            end
          end else begin
            next_wait_cycles = wait_cycles + 32'h0000_0001;
          end
        end
        ssr_pkg::SSR_ST_NEXT: begin
          next_repeat_done_fsm = step_next_repeat;
          if (!step_advance) begin
            next_state = ssr_pkg::SSR_ST_FETCH;
          end else if (slot == `SSR_SLOT_LAST) begin
            next_state = ssr_pkg::SSR_ST_IDLE;
          end else begin
            next_state = ssr_pkg::SSR_ST_FETCH;
            next_slot = slot + 3'h1;
          end
        end
        default: begin
          next_state = ssr_pkg::SSR_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ssr_pkg::SSR_ST_IDLE;
      slot <= 3'h0;
      repeat_done <= `SSR_REPEAT_ZERO;
      wait_units <= 7'h00;
      wait_cycles <= 32'h0000_0000;
      play_req <= 1'b0;
      play_id <= 7'h00;
      seq_busy <= 1'b0;
    end else begin
      state <= next_state;
      slot <= next_slot;
      repeat_done <= next_repeat_done_fsm;
      wait_units <= next_wait_units;
      wait_cycles <= next_wait_cycles;
      play_req <= next_play_req;
      play_id <= next_play_id;
      seq_busy <= (next_state != ssr_pkg::SSR_ST_IDLE);
    end
  end

endmodule : ssr_top
`default_nettype wire

// ==== sim/ssr_top_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssr_top_properties #(
  parameter int WAIT_UNIT_CYCLES = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Engine and state.
  input wire logic play_req,
  input wire logic [6:0] play_id,
  input wire logic play_done,
  input wire logic seq_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_pready_zero_wait: assert property (psel && !penable |=> pready) else $error("pready late");
  a_pready_pulse: assert property (pready |-> psel && penable ##1 !pready) else $error("pready shape");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_unmapped_err: assert property (psel && !penable && paddr == 8'h64 |=> pslverr) else $error("no error");
  a_play_spacing: assert property (play_req |=> !play_req [*2]) else $error("play too soon");
  a_play_busy: assert property (play_req |-> seq_busy) else $error("play while idle");
  a_go_starts: assert property (psel && penable && pready && pwrite && paddr == 8'h30 && pwdata[0]
    |=> ##[0:2] seq_busy) else $error("go ignored");
  cover property (play_req);
  cover property ($fell(seq_busy));
  cover property (pslverr);
endmodule : ssr_top_properties
bind ssr_top ssr_top_properties #(.WAIT_UNIT_CYCLES(WAIT_UNIT_CYCLES)) i_props (
  .clk(clk),
  .rst_b(rst_b),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .play_req(play_req),
  .play_id(play_id),
  .play_done(play_done),
  .seq_busy(seq_busy)
);
`default_nettype wire

// ==== sim/ssr_top_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssr_top_tb_top;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, play_done = 0, pd1 = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, play_req, seq_busy;
  logic [6:0] play_id;
  int err_count = 0, cmp_count = 0, cyc = 0, t2 = 0, t4 = 0, i;
  int cnt [0:127];
  ssr_top #(.WAIT_UNIT_CYCLES(50)) i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .play_req(play_req), .play_id(play_id), .play_done(play_done), .seq_busy(seq_busy));
  initial forever #2 clk = ~clk;
  // The engine answers each play two cycles later, slow enough to expose a missed handshake.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pd1 <= play_req;
    play_done <= pd1;
    if (play_req === 1'b1) cnt[play_id] <= cnt[play_id] + 1;
    if (play_req === 1'b1 && play_id === 7'h02) t2 <= cyc;
    if (play_req === 1'b1 && play_id === 7'h04 && t4 == 0) t4 <= cyc;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait; the master assumes no answer time.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic run_seq();
    apb(1'b1, 8'h30, 32'h1);
    repeat (3) @(posedge clk);
    while (seq_busy !== 1'b0) begin
      @(posedge clk);
    end
  endtask : run_seq
  initial begin
    foreach (cnt[k]) cnt[k] <= 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h5C, 32'h0);
    chk("low reset", 32'h0, rd);
    apb(1'b0, 8'h60, 32'h0);
    chk("high reset", 32'h0, rd);
    apb(1'b1, 8'h5C, 32'hE4);
    apb(1'b1, 8'h60, 32'h1B);
    apb(1'b0, 8'h5C, 32'h0);
    chk("low readback", 32'hE4, rd);
    apb(1'b0, 8'h60, 32'h0);
    chk("high readback", 32'h1B, rd);
    apb(1'b0, 8'h64, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    // Slot three waits three units with an id no other slot uses, so a wrongly played wait shows.
    for (i = 0; i < 8; i++) apb(1'b1, 8'(8'h3C + 4 * i), (i == 2) ? 32'h83 : 32'(i + 1));
    run_seq();
    for (i = 0; i < 8; i++) if (i != 2) chk("plays", 32'(((16'h1BE4 >> (2 * i)) & 3) + 1), 32'(cnt[i + 1]));
    chk("wait not played", 32'h0, 32'(cnt[3]));
    chk("wait gap", 32'h1, 32'(t4 - t2 >= 450 && t4 - t2 < 480));
    foreach (cnt[k]) cnt[k] <= 0;
    apb(1'b1, 8'h5C, 32'h03);
    apb(1'b1, 8'h40, 32'h0);
    // Abort after two plays of slot one, so its repetition counter is left part way.
    apb(1'b1, 8'h30, 32'h1);
    while (cnt[1] != 2) @(posedge clk);
    apb(1'b1, 8'h30, 32'h0);
    chk("abort idle", 32'h0, 32'(seq_busy));
    apb(1'b0, 8'h30, 32'h0);
    chk("go readback", 32'h0, rd);
    foreach (cnt[k]) cnt[k] <= 0;
    run_seq();
    chk("halt first", 32'h4, 32'(cnt[1]));
    chk("halt second", 32'h0, 32'(cnt[2]));
    chk("halt zero", 32'h0, 32'(cnt[0]));
    chk("halt later", 32'h0, 32'(cnt[4]));
    apb(1'b0, 8'h7C, 32'h0);
    chk("status after halt", 32'h2, rd);
    close_out();
  end
endmodule : ssr_top_tb_top
`default_nettype wire
